//--- verilog/tasc_pkg.sv
// Constants and types for the translation address size checker.
package tasc_pkg;
  // ***************************************
  // Implementation choices of the unit.
  // ***************************************
  localparam logic [6:0] OUT_ADDR_BITS = 7'd48;
  localparam logic [1:0] TABLE_FORMAT_SUPPORT = 2'b11;
  localparam logic EXTENDED_VA_CAPABILITY = 1'b1;
  localparam logic LATER_REVISION = 1'b1;
  localparam logic STAGE1_IMPL = 1'b1;
  localparam logic STAGE2_IMPL = 1'b1;
  localparam logic [6:0] FMT32_BITS = 7'd40;
  localparam logic [6:0] SPAN_MAX = 7'd48;
  localparam logic [6:0] SPAN_MAX_64K = 7'd52;
  localparam logic [6:0] VA32_BITS = 7'd32;
  // ***************************************
  // Register word offsets and count.
  // ***************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SPAN_OFS = 8'h04;
  localparam logic [7:0] S2TB_LO_OFS = 8'h08;
  localparam logic [7:0] S2TB_HI_OFS = 8'h0c;
  localparam logic [7:0] LOTB_LO_OFS = 8'h10;
  localparam logic [7:0] LOTB_HI_OFS = 8'h14;
  localparam logic [7:0] HITB_LO_OFS = 8'h18;
  localparam logic [7:0] HITB_HI_OFS = 8'h1c;
  localparam logic [7:0] STAT_OFS = 8'h20;
  localparam logic [7:0] FADDR_LO_OFS = 8'h24;
  localparam logic [7:0] FADDR_HI_OFS = 8'h28;
  localparam int NUM_CFG = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // ***************************************
  // Field positions in the control word.
  // ***************************************
  localparam int CTL_EN = 0;
  localparam int CTL_GBA = 1;
  localparam int CTL_SEL = 2;
  localparam int CTL_SDB = 5;
  localparam int CTL_S2F64 = 7;
  localparam int CTL_CDF64 = 8;
  localparam int CTL_TOPBYTE = 9;
  localparam int CTL_ATTR = 10;
  localparam int CTL_LOG64 = 11;
  localparam int CTL_HIG64 = 12;
  localparam int CTL_S2G64 = 13;
  // Field positions in the span word.
  localparam int SPN_LO = 0;
  localparam int SPN_HI = 8;
  localparam int SPN_S2 = 16;
  localparam int SPN_CTXSZ = 24;
  localparam int SPN_S2SZ = 28;
  // Encodings.
  localparam logic [2:0] SEL_BYPASS = 3'b100;
  localparam logic [1:0] SDB_BYPASS = 2'b01;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  // Outcome of one address check.
  typedef enum logic [2:0] {
    TASC_OK, TASC_S1_TRANS, TASC_S1_SIZE, TASC_S2_TRANS,
    TASC_S2_SIZE, TASC_BAD_ENTRY, TASC_BAD_CTX, TASC_ABORT_SILENT
  } tasc_fault_e;
endpackage

//--- verilog/tasc_checker.sv
// Address size checker on the two-stage translation path.
`timescale 1ns/1ns
// Notes on behaviour
// - Descriptor top bits reserved, except attribute bits.
// - Input addresses are always 64 bits.
// - Intermediate width is max of 40, output width.
// - 32-bit format results fit output width.
// - Disabled unit passes address unless global_bypass_abort; oversize aborts silently.
// - Full bypass oversize aborts with stage 1 size.
// - 32-bit stage 1 input checked within 32 bits.
// - 64-bit table spans capped 48, or 52.
// - Bits above range match top; top byte exempt.
// - 32-bit stage 1 output limited to 40 bits.
// - 64-bit stage 1 output limited by capped size.
// - Stage 1 bypass checks intermediate width.
// - Stage 2 input limited by span, capped.
// - Both widths 52: stage 2 input 48 unless 64KB.
// - 64-bit stage 2 output limited by capped size.
// - 32-bit stage 2 output 40 bits, then truncated.
// - Narrow stage 2 results zero-extended.
// - Stage 2 bypass truncates or zero-extends.
// - Table bases out of range are config faults.
// - Fault records hold input address unmodified.
module tasc_checker (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic req_valid,
  input wire logic [63:0] req_addr,
  input wire logic [63:0] s1_out_addr,
  input wire logic [63:0] s2_out_addr,
  input wire logic [3:0] s2_desc_top,
  output logic done_q,
  output logic abort_q,
  output logic [63:0] out_addr_q,
  output logic [2:0] page_attr_q,
  output logic fault_valid_q,
  output logic [2:0] fault_code_q,
  output logic [63:0] fault_addr_q
);
  // ***************************************
  // Helper functions.
  // ***************************************
  // Size field code to address bits.
  function automatic logic [6:0] ps_bits(input logic [2:0] c);
    case (c)
      3'd0: ps_bits = 7'd32;
      3'd1: ps_bits = 7'd36;
      3'd2: ps_bits = 7'd40;
      3'd3: ps_bits = 7'd42;
      3'd4: ps_bits = 7'd44;
      3'd5: ps_bits = 7'd48;
      default: ps_bits = 7'd52;
    endcase
  endfunction
  // Lesser of two widths.
  function automatic logic [6:0] wmin(input logic [6:0] a,
                                     input logic [6:0] b);
    wmin = (a < b) ? a : b;
  endfunction
  // True when the address has no set bit at or above n.
  function automatic logic fits(input logic [63:0] a,
                                input logic [6:0] n);
    fits = ((a >> n) == 64'h0);
  endfunction
  // Address cut to n bits, upper bits zero.
  function automatic logic [63:0] trunc(input logic [63:0] a,
                                        input logic [6:0] n);
    trunc = a & ~(64'hffff_ffff_ffff_ffff << n);
  endfunction
  // True when bits n-1 up to top all equal bit top.
  function automatic logic sext_ok(input logic [63:0] a,
                                   input logic [6:0] n,
                                   input logic [6:0] top);
    int i;
    sext_ok = 1'b1;
    for (i = 0; i < 64; i++) begin
      if ((i + 1 >= int'(n)) && (i <= int'(top)) &&
          (a[i] != a[top[5:0]])) begin
        sext_ok = 1'b0;
      end
    end
  endfunction
  // Span field to range width, capped.
  function automatic logic [6:0] span_bits(input logic [5:0] sz,
                                           input logic [6:0] cap);
    span_bits = wmin(7'd64 - {1'b0, sz}, cap);
  endfunction

  // ***************************************
  // Derived widths.
  // ***************************************
  // intermediate width derivation
  localparam logic [6:0] IA_FMT32 = tasc_pkg::TABLE_FORMAT_SUPPORT[0] ?
                                    tasc_pkg::FMT32_BITS : 7'd0;
  localparam logic [6:0] IA_FMT64 = tasc_pkg::TABLE_FORMAT_SUPPORT[1] ?
                                    tasc_pkg::OUT_ADDR_BITS : 7'd0;
  localparam logic [6:0] IA_BITS = (IA_FMT32 > IA_FMT64) ?
                                   IA_FMT32 : IA_FMT64;
  localparam logic WIDE52 = tasc_pkg::LATER_REVISION &&
                            (tasc_pkg::OUT_ADDR_BITS == 7'd52) &&
                            (IA_BITS == 7'd52);

  // ***************************************
  // Register bus slave.
  // ***************************************
  logic [31:0] cfg_q [tasc_pkg::NUM_CFG];
  logic wr_pend_q;
  logic [2:0] wr_idx_q;
  logic [31:0] stat_q;
  logic [63:0] last_faddr_q;
  wire addr_ok = hsel && hready && htrans[1];
  wire [7:0] ofs = haddr[7:0];
  wire in_cfg = (haddr[31:5] == 27'h0) && (ofs[1:0] == 2'b00);
  wire [31:0] rd_mux =
    in_cfg ? cfg_q[ofs[4:2]] :
    (haddr == {24'h0, tasc_pkg::STAT_OFS}) ? stat_q :
    (haddr == {24'h0, tasc_pkg::FADDR_LO_OFS}) ?
      last_faddr_q[31:0] :
    (haddr == {24'h0, tasc_pkg::FADDR_HI_OFS}) ?
      last_faddr_q[63:32] : 32'h0;

  // Capture the write target in the address phase.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 3'd0;
    end else if (hready) begin
      wr_pend_q <= addr_ok && hwrite && in_cfg;
      wr_idx_q <= ofs[4:2];
    end
  end

  // Store write data in the data phase.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int k = 0; k < tasc_pkg::NUM_CFG; k++) begin
        cfg_q[k] <= tasc_pkg::CFG_RESET;
      end
    end else if (wr_pend_q) begin
      cfg_q[wr_idx_q] <= hwdata;
    end
  end

  // Read data is ready at the start of the data phase.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // ***************************************
  // Configuration fields.
  // ***************************************
  wire [31:0] ctl = cfg_q[tasc_pkg::CTRL_OFS[4:2]];
  wire [31:0] spn = cfg_q[tasc_pkg::SPAN_OFS[4:2]];
  wire [63:0] s2_base = {cfg_q[tasc_pkg::S2TB_HI_OFS[4:2]],
                         cfg_q[tasc_pkg::S2TB_LO_OFS[4:2]]};
  wire [63:0] lo_base = {cfg_q[tasc_pkg::LOTB_HI_OFS[4:2]],
                         cfg_q[tasc_pkg::LOTB_LO_OFS[4:2]]};
  wire [63:0] hi_base = {cfg_q[tasc_pkg::HITB_HI_OFS[4:2]],
                         cfg_q[tasc_pkg::HITB_LO_OFS[4:2]]};
  wire unit_global_enable = ctl[tasc_pkg::CTL_EN];
  wire global_bypass_abort = ctl[tasc_pkg::CTL_GBA];
  wire [2:0] stream_stage_select = ctl[tasc_pkg::CTL_SEL +: 3];
  wire [1:0] substream_default_behaviour =
    ctl[tasc_pkg::CTL_SDB +: 2];
  wire stage2_format_select = ctl[tasc_pkg::CTL_S2F64];
  wire ctx_fmt64 = ctl[tasc_pkg::CTL_CDF64];
  wire top_byte_ignore = ctl[tasc_pkg::CTL_TOPBYTE];
  wire page_hw_attribute_bits = ctl[tasc_pkg::CTL_ATTR];
  wire stage2_granule = ctl[tasc_pkg::CTL_S2G64];
  wire [5:0] low_table_span = spn[tasc_pkg::SPN_LO +: 6];
  wire [5:0] high_table_span = spn[tasc_pkg::SPN_HI +: 6];
  wire [5:0] stage2_input_span = spn[tasc_pkg::SPN_S2 +: 6];
  wire [2:0] context_intermediate_size = spn[tasc_pkg::SPN_CTXSZ +: 3];
  wire [2:0] stage2_phys_size = spn[tasc_pkg::SPN_S2SZ +: 3];

  // ***************************************
  // Stage 1 input check.
  // ***************************************
  // whole 64-bit address used
  wire [63:0] va = req_addr;
  wire s1_on = stream_stage_select[0] && tasc_pkg::STAGE1_IMPL &&
               (substream_default_behaviour != tasc_pkg::SDB_BYPASS);
  wire [6:0] addr_top = top_byte_ignore ? 7'd55 : 7'd63;
  wire hi_sel64 = va[addr_top[5:0]];
  wire hi_sel32 = va[31];
  wire use_hi = ctx_fmt64 ? hi_sel64 : hi_sel32;
  wire lo_g64 = ctl[tasc_pkg::CTL_LOG64] &&
                tasc_pkg::EXTENDED_VA_CAPABILITY &&
                tasc_pkg::LATER_REVISION;
  wire hi_g64 = ctl[tasc_pkg::CTL_HIG64] &&
                tasc_pkg::EXTENDED_VA_CAPABILITY &&
                tasc_pkg::LATER_REVISION;
  wire [6:0] lo_cap = lo_g64 ? tasc_pkg::SPAN_MAX_64K :
                               tasc_pkg::SPAN_MAX;
  wire [6:0] hi_cap = hi_g64 ? tasc_pkg::SPAN_MAX_64K :
                               tasc_pkg::SPAN_MAX;
  wire [6:0] lo_n = span_bits(low_table_span, lo_cap);
  wire [6:0] hi_n = span_bits(high_table_span, hi_cap);
  wire ok64 = sext_ok(va, use_hi ? hi_n : lo_n, addr_top);
  // fixed 32-bit range split by spans
  wire [6:0] lo_n32 = 7'd32 - {1'b0, low_table_span};
  wire [6:0] hi_n32 = 7'd32 - {1'b0, high_table_span};
  wire lo_hit32 = fits(va, lo_n32);
  wire hi_hit32 = fits(va, tasc_pkg::VA32_BITS) &&
                  sext_ok({32'h0, va[31:0]}, hi_n32, 7'd31);
  wire ok32 = fits(va, tasc_pkg::VA32_BITS) &&
              (hi_sel32 ? hi_hit32 : lo_hit32);
  wire s1_in_ok = ctx_fmt64 ? ok64 : ok32;

  // ***************************************
  // Stage 1 output check.
  // ***************************************
  // 32-bit contexts fixed at 40
  wire [6:0] s1_lim = ctx_fmt64 ?
    wmin(ps_bits(context_intermediate_size), tasc_pkg::OUT_ADDR_BITS) :
    tasc_pkg::FMT32_BITS;
  wire s1_out_ok = fits(s1_out_addr, s1_lim);
  // bypassed stage 1 checked against intermediate width
  wire [63:0] ipa = s1_on ? s1_out_addr : va;
  wire byp_ok = fits(va, IA_BITS);

  // ***************************************
  // Stage 2 checks.
  // ***************************************
  wire s2_on = stream_stage_select[1] && tasc_pkg::STAGE2_IMPL;
  wire [6:0] s2_in_cap0 = stage2_format_select ? IA_BITS :
                                                tasc_pkg::FMT32_BITS;
  wire [6:0] s2_in_cap = (WIDE52 && !stage2_granule) ?
                         wmin(s2_in_cap0, tasc_pkg::SPAN_MAX) :
                         s2_in_cap0;
  wire [6:0] s2_in_n = span_bits(stage2_input_span, s2_in_cap);
  wire s2_in_ok = fits(ipa, s2_in_n);
  // capped size, 52 only with 64KB
  wire [6:0] s2_ps = wmin(ps_bits(stage2_phys_size),
                          tasc_pkg::OUT_ADDR_BITS);
  wire [6:0] s2_ps_g = (s2_ps == 7'd52 && !stage2_granule) ?
                       tasc_pkg::SPAN_MAX : s2_ps;
  wire [6:0] s2_lim = stage2_format_select ? s2_ps_g :
                                             tasc_pkg::FMT32_BITS;
  wire s2_out_ok = fits(s2_out_addr, s2_lim);

  // ***************************************
  // Configuration structure checks.
  // ***************************************
  // table bases against output sizes
  wire bad_entry = s2_on && !fits(s2_base, s2_lim);
  wire bad_ctx = s1_on && !fits(use_hi ? hi_base : lo_base, s1_lim);

  // ***************************************
  // Final address.
  // ***************************************
  // 40-bit results fitted to output width
  // bypassed stage 2 truncates or extends
  wire [63:0] pa = trunc(s2_on ? s2_out_addr : ipa,
                         tasc_pkg::OUT_ADDR_BITS);
  wire gb_ok = fits(va, tasc_pkg::OUT_ADDR_BITS);

  // ***************************************
  // Ordered outcome.
  // ***************************************
  tasc_pkg::tasc_fault_e verdict;
  always_comb begin
    verdict = tasc_pkg::TASC_OK;
    if (!unit_global_enable) begin
      if (global_bypass_abort || !gb_ok) begin
        verdict = tasc_pkg::TASC_ABORT_SILENT;
      end
    end else if (stream_stage_select == tasc_pkg::SEL_BYPASS) begin
      if (!gb_ok) begin
        verdict = tasc_pkg::TASC_S1_SIZE;
      end
    end else if (bad_entry) begin
      verdict = tasc_pkg::TASC_BAD_ENTRY;
    end else if (bad_ctx) begin
      verdict = tasc_pkg::TASC_BAD_CTX;
    end else if (s1_on && !s1_in_ok) begin
      verdict = tasc_pkg::TASC_S1_TRANS;
    end else if (s1_on && !s1_out_ok) begin
      verdict = tasc_pkg::TASC_S1_SIZE;
    end else if (!s1_on && !byp_ok) begin
      verdict = tasc_pkg::TASC_S1_SIZE;
    end else if (s2_on && !s2_in_ok) begin
      verdict = tasc_pkg::TASC_S2_TRANS;
    end else if (s2_on && !s2_out_ok) begin
      verdict = tasc_pkg::TASC_S2_SIZE;
    end
  end

  wire is_ok = (verdict == tasc_pkg::TASC_OK);
  wire is_evt = !is_ok &&
                (verdict != tasc_pkg::TASC_ABORT_SILENT);
  wire pass_through = !unit_global_enable ||
    (stream_stage_select == tasc_pkg::SEL_BYPASS);
  // only attribute bits pass, rest ignored
  wire [2:0] attr = (page_hw_attribute_bits ||
                     !tasc_pkg::LATER_REVISION) && s2_on ?
                    s2_desc_top[2:0] : 3'b000;

  // ***************************************
  // Result registers.
  // ***************************************
  // Register one result per accepted request.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_q <= 1'b0;
      abort_q <= 1'b0;
      out_addr_q <= 64'h0;
      page_attr_q <= 3'b000;
      fault_valid_q <= 1'b0;
      fault_code_q <= 3'b000;
      fault_addr_q <= 64'h0;
    end else begin
      done_q <= req_valid;
      abort_q <= req_valid && !is_ok;
      fault_valid_q <= req_valid && is_evt;
      if (req_valid) begin
        out_addr_q <= !is_ok ? 64'h0 :
                      pass_through ? va : pa;
        page_attr_q <= is_ok ? attr : 3'b000;
        fault_code_q <= verdict;
        fault_addr_q <= va;
      end
    end
  end

  // Status shows the last outcome and faulting address.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stat_q <= 32'h0;
      last_faddr_q <= 64'h0;
    end else if (req_valid) begin
      stat_q <= {28'h0, is_evt, verdict};
      if (is_evt) begin
        last_faddr_q <= va;
      end
    end
  end
endmodule

//--- tb/tasc_prop_checker.sv
// Concurrent checks on the transaction ports of the address checker.
`timescale 1ns/1ns
module tasc_prop_checker (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic [63:0] req_addr,
  input wire logic [3:0] s2_desc_top,
  input wire logic done_q,
  input wire logic abort_q,
  input wire logic [63:0] out_addr_q,
  input wire logic [2:0] page_attr_q,
  input wire logic fault_valid_q,
  input wire logic [2:0] fault_code_q,
  input wire logic [63:0] fault_addr_q
);
  // Descriptor bits that may reach the attribute output.
  wire logic [2:0] attr_src;
  assign attr_src = s2_desc_top[2:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ***************************************
  // Assertions.
  // ***************************************
  a_done_timing: assert property (req_valid |=> done_q)
    else $error("No answer one cycle after a request.");
  a_no_spurious: assert property (!req_valid |=>
    !done_q && !abort_q && !fault_valid_q)
    else $error("Answer pulse without a request.");
  a_event_cause: assert property (fault_valid_q |->
    done_q && abort_q && fault_code_q inside {[3'h1:3'h6]})
    else $error("Event without an aborting fault.");
  a_silent_abort: assert property (
    done_q && fault_code_q == 3'h7 |-> abort_q && !fault_valid_q)
    else $error("Silent abort recorded an event.");
  a_clean_pass: assert property (
    done_q && fault_code_q == 3'h0 |-> !abort_q && !fault_valid_q)
    else $error("Clean outcome aborted.");
  a_abort_zero: assert property (abort_q |-> out_addr_q == 64'h0)
    else $error("Aborted request left an address.");
  a_out_width: assert property (done_q |->
    (out_addr_q >> tasc_pkg::OUT_ADDR_BITS) == 64'h0)
    else $error("Output address wider than the output width.");
  a_record_addr: assert property (
    req_valid |=> fault_addr_q == $past(req_addr))
    else $error("Recorded address differs from the input.");
  a_attr_source: assert property (
    done_q && page_attr_q != 3'h0 |-> page_attr_q == $past(attr_src))
    else $error("Attribute bits not from the descriptor.");
  a_out_held: assert property (!req_valid |=>
    $stable(out_addr_q) && $stable(fault_code_q))
    else $error("Result changed without a request.");
  // Main outcomes that the bench should reach.
  c_silent: cover property (done_q && fault_code_q == 3'h7);
  c_event: cover property (fault_valid_q);
  c_attr: cover property (done_q && page_attr_q != 3'h0);
endmodule
bind tasc_checker tasc_prop_checker tasc_prop_checker_i (
  .core_clk(core_clk), .srst(srst), .req_valid(req_valid),
  .req_addr(req_addr), .s2_desc_top(s2_desc_top), .done_q(done_q),
  .abort_q(abort_q), .out_addr_q(out_addr_q), .page_attr_q(page_attr_q),
  .fault_valid_q(fault_valid_q), .fault_code_q(fault_code_q),
  .fault_addr_q(fault_addr_q));

//--- tb/tasc_walker_model.sv
// Behavioural table walker that answers the checker's requests.
`timescale 1ns/1ns
module tasc_walker_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic [63:0] ipa_set,
  input wire logic [63:0] pa_set,
  input wire logic [3:0] top_set,
  output logic [63:0] s1_out_addr,
  output logic [63:0] s2_out_addr,
  output logic [3:0] s2_desc_top
);
  logic [63:0] ipa_q;
  logic [63:0] pa_q;
  logic [3:0] top_q;
  // Keeps the last answer so an idle bus can show its inverse.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ipa_q <= 64'h0;
      pa_q <= 64'h0;
      top_q <= 4'h0;
    end else if (req_valid) begin
      ipa_q <= ipa_set;
      pa_q <= pa_set;
      top_q <= top_set;
    end
  end
  // raw descriptor bits
  // Results stand only with the request; stale values never linger.
  assign s1_out_addr = req_valid ? ipa_set : ~ipa_q;
  assign s2_out_addr = req_valid ? pa_set : ~pa_q;
  assign s2_desc_top = req_valid ? top_set : ~top_q;
endmodule

//--- tb/tasc_checker_tb_top.sv
// Self-checking bench for the translation address checker.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end
module tasc_checker_tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic req_valid = 1'b0;
  logic [63:0] req_addr = 64'h0;
  logic [63:0] ipa_set = 64'h0;
  logic [63:0] pa_set = 64'h0;
  logic [3:0] top_set = 4'h0;
  wire logic hready, hreadyout, hresp, done_q, abort_q, fault_valid_q;
  wire logic [31:0] hrdata;
  wire logic [63:0] s1_out_addr, s2_out_addr, out_addr_q, fault_addr_q;
  wire logic [3:0] s2_desc_top;
  wire logic [2:0] page_attr_q, fault_code_q;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] rdat;
  // The one slave's ready is the bus ready.
  assign hready = hreadyout;
  tasc_checker tasc_checker_i (.core_clk(core_clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .req_valid(req_valid), .req_addr(req_addr),
    .s1_out_addr(s1_out_addr), .s2_out_addr(s2_out_addr),
    .s2_desc_top(s2_desc_top), .done_q(done_q), .abort_q(abort_q),
    .out_addr_q(out_addr_q), .page_attr_q(page_attr_q),
    .fault_valid_q(fault_valid_q), .fault_code_q(fault_code_q),
    .fault_addr_q(fault_addr_q));
  tasc_walker_model tasc_walker_model_i (.core_clk(core_clk),
    .srst(srst), .req_valid(req_valid), .ipa_set(ipa_set),
    .pa_set(pa_set), .top_set(top_set), .s1_out_addr(s1_out_addr),
    .s2_out_addr(s2_out_addr), .s2_desc_top(s2_desc_top));
  // Makes the 50 MHz clock.
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // ***************************************
  // Bus and request tasks.
  // ***************************************
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= tasc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rdat = hrdata;
  endtask
  task automatic cfg(input logic [31:0] c, input logic [31:0] s);
    bus(1'b1, tasc_pkg::CTRL_OFS, c);
    bus(1'b1, tasc_pkg::SPAN_OFS, s);
  endtask
  task automatic xact(input logic [63:0] va, input logic [63:0] ipa,
    input logic [63:0] pa, input logic [3:0] top, input logic [2:0] code,
    input logic [63:0] eo, input logic [2:0] ea);
    req_valid <= 1'b1;
    req_addr <= va;
    ipa_set <= ipa;
    pa_set <= pa;
    top_set <= top;
    @(posedge core_clk);
    req_valid <= 1'b0;
    @(posedge core_clk);
    `CHK("done", 1'b1, done_q)
    `CHK("code", code, fault_code_q)
    `CHK("abort", code != 3'h0, abort_q)
    `CHK("event", code != 3'h0 && code != 3'h7, fault_valid_q)
    `CHK("out", (code != 3'h0) ? 64'h0 : eo, out_addr_q)
    `CHK("attr", ea, page_attr_q)
    `CHK("faddr", va, fault_addr_q)
  endtask
  // ***************************************
  // Scenarios.
  // ***************************************
  task automatic t_regs;
    bus(1'b0, tasc_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl reset", tasc_pkg::CFG_RESET, rdat)
    bus(1'b1, 8'h2c, 32'hffff_ffff);
    bus(1'b0, 8'h2c, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    `CHK("hresp", 1'b0, hresp)
    `CHK("ready", 1'b1, hreadyout)
  endtask
  task automatic t_global;
    cfg(32'h0, 32'h0);
    xact(64'hffff_ffff_ffff, 0, 0, 0, 3'h0, 64'hffff_ffff_ffff, 0);
    xact(64'h0001_0000_0000_0000, 0, 0, 0, 3'h7, 0, 0);
    cfg(32'h2, 32'h0);
    xact(64'h1000, 0, 0, 0, 3'h7, 0, 0);
  endtask
  task automatic t_bypass;
    cfg(32'h11, 32'h0);
    xact(64'h8000_0000_0000_1234, 0, 0, 0, 3'h2, 0, 0);
    bus(1'b0, tasc_pkg::STAT_OFS, 32'h0);
    `CHK("status", 32'ha, rdat)
    bus(1'b0, tasc_pkg::FADDR_HI_OFS, 32'h0);
    `CHK("fault hi", 32'h8000_0000, rdat)
    xact(64'h1234, 0, 0, 0, 3'h0, 64'h1234, 0);
  endtask
  task automatic t_s1_64;
    cfg(32'h115, 32'h0200_1010);
    xact(64'h7fff_ffff_f000, 64'hff_ffff_f000, 0, 0, 0,
         64'hff_ffff_f000, 0);
    xact(64'h8000_0000_0000, 0, 0, 0, 3'h1, 0, 0);
    xact(64'hffff_8000_0000_0000, 64'h1000, 0, 0, 0, 64'h1000, 0);
    xact(64'h1000, 64'h100_0000_0000, 0, 0, 3'h2, 0, 0);
    xact(64'h8000_0000_0000, 64'h100_0000_0000, 0, 0, 3'h1, 0, 0);
    cfg(32'h115, 32'h0200_100c);
    xact(64'h0004_0000_0000_0000, 64'h1000, 0, 0, 3'h1, 0, 0);
    cfg(32'h915, 32'h0200_100c);
    xact(64'h0004_0000_0000_0000, 64'h1000, 0, 0, 0, 64'h1000, 0);
    cfg(32'h1115, 32'h0200_0c10);
    xact(64'hfff8_0000_0000_0000, 64'h1000, 0, 0, 0, 64'h1000, 0);
    cfg(32'h315, 32'h0200_1010);
    xact(64'hab00_0000_0000_1000, 64'h2000, 0, 0, 0, 64'h2000, 0);
    bus(1'b1, tasc_pkg::LOTB_HI_OFS, 32'h100);
    xact(64'h1000, 64'h2000, 0, 0, 3'h6, 0, 0);
    bus(1'b1, tasc_pkg::LOTB_HI_OFS, 32'h0);
  endtask
  task automatic t_s1_32;
    cfg(32'h15, 32'h0);
    xact(64'h1_0000_0000, 0, 0, 0, 3'h1, 0, 0);
    xact(64'h8000_0000, 64'hff_ffff_f000, 0, 0, 0,
         64'hff_ffff_f000, 0);
    xact(64'h8000_0000, 64'h100_0000_0000, 0, 0, 3'h2, 0, 0);
  endtask
  task automatic t_s2;
    cfg(32'h99, 32'h2018_0000);
    xact(64'h0001_0000_0000_0000, 0, 0, 0, 3'h2, 0, 0);
    xact(64'h100_0000_0000, 0, 0, 0, 3'h3, 0, 0);
    xact(64'hff_ffff_f000, 0, 64'h100_0000_0000, 0, 3'h4, 0, 0);
    xact(64'h12_3456_7000, 0, 64'hab_cdef_0000, 4'hd, 0,
         64'hab_cdef_0000, 0);
    cfg(32'h499, 32'h2018_0000);
    xact(64'h12_3456_7000, 0, 64'hab_cdef_0000, 4'hd, 0,
         64'hab_cdef_0000, 3'h5);
    bus(1'b1, tasc_pkg::S2TB_HI_OFS, 32'h100);
    xact(64'h1000, 0, 64'h1000, 0, 3'h5, 0, 0);
    bus(1'b1, tasc_pkg::S2TB_HI_OFS, 32'h0);
    cfg(32'h99, 32'h6018_0000);
    xact(64'h1000, 0, 64'h8000_0000_0000, 0, 0, 64'h8000_0000_0000,
         0);
    xact(64'h1000, 0, 64'h1_0000_0000_0000, 0, 3'h4, 0, 0);
    cfg(32'h19, 32'h0);
    xact(64'h100_0000_0000, 0, 0, 0, 3'h3, 0, 0);
    xact(64'h12_3456_7000, 0, 64'hab_cdef_0000, 0, 0,
         64'hab_cdef_0000, 0);
    xact(64'h1000, 0, 64'h100_0000_0000, 0, 3'h4, 0, 0);
    cfg(32'hbd, 32'h2018_0000);
    xact(64'h0001_0000_0000_0000, 0, 0, 0, 3'h2, 0, 0);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence after the reset interval.
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_regs;
    t_global;
    t_bypass;
    t_s1_64;
    t_s1_32;
    t_s2;
    stop_test;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    stop_test;
  end
endmodule
